// ---- hdl/watchdog_defs.svh ----
// Watchdog constants: reset values, field layout and time base.
// Assumes inclusion by bare name from the watchdog package and modules.
`ifndef WATCHDOG_DEFS_SVH
`define WATCHDOG_DEFS_SVH

// ----------------------------------------------------------------------
// Time base
// ----------------------------------------------------------------------
`define WD_LFOSC_KHZ       80
`define WD_SYSCLK_KHZ      10000
`define WD_CNT_W           16

// ----------------------------------------------------------------------
// Interval field
// ----------------------------------------------------------------------
`define WD_INTERVAL_W      3
`define WD_INTERVAL_BASE   9
`define WD_INTERVAL_RST    3'h7

// ----------------------------------------------------------------------
// Reset values of control state
// ----------------------------------------------------------------------
`define WD_LOCK_RST        1'h0

`endif

// ---- hdl/watchdog_pkg.sv ----
// Types shared by the watchdog modules.
// Assumes watchdog_defs.svh is on the include path.
`include "watchdog_defs.svh"

package watchdog_pkg;

  typedef enum logic [1:0]
  {
    ST_OFF   = 2'b00,
    ST_RUN   = 2'b01,
    ST_FIRED = 2'b10
  } wd_state_t;

  typedef struct packed
  {
    logic                        enable;
    logic                        lock;
    logic [`WD_INTERVAL_W-1:0]   interval;
  } wd_cfg_t;

  typedef struct packed
  {
    logic                        enabled;
    logic                        locked;
    logic                        fired;
    logic [`WD_INTERVAL_W-1:0]   interval;
    logic [`WD_CNT_W-1:0]        count;
  } wd_status_t;

endpackage : watchdog_pkg

// ---- hdl/osc_edge_sync.sv ----
// Two-flop synchroniser with rising-edge pulse for a slow foreign clock.
// Assumes the sampled clock is much slower than clk.
`timescale 1ns/100ps

module osc_edge_sync
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic async_in,
  output wire logic rise_pulse
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      // Start high: a pin already high at release is not a rising edge
      meta_ff <= 1'h1;
      sync_ff <= 1'h1;
      last_ff <= 1'h1;
    end
    else if (clk_en)
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // Edge only from the second stage onward
  assign rise_pulse = clk_en & sync_ff & ~last_ff;

endmodule : osc_edge_sync

// ---- hdl/watchdog_unit.sv ----
// Watchdog timer counting low-frequency oscillator edges.
// Assumes clk at 10 MHz, low_freq_osc a free-running 80 kHz pin-level clock,
// and that sys_reset_req is fed back by the system into reset.
//
// Contract
// - An overflow of the count drives the whole controller into reset.
// - After any reset the watchdog runs enabled at the longest interval.
// - Software may disable the watchdog or lock it on.
// - Once locked, disable attempts are ignored until the next system reset.
// - Once locked, no configuration change, interval included, takes effect.
// - A watchdog reset never drives or changes the external reset pin.
// - The count advances on the low-frequency oscillator, not the system clock.
// - The low-frequency oscillator runs at 80 kHz and sets the time base.
`timescale 1ns/100ps
`include "watchdog_defs.svh"

module watchdog_unit
#(
  parameter int CNT_W         = `WD_CNT_W,
  parameter int INTERVAL_BASE = `WD_INTERVAL_BASE
)
(
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    clk_en,
  input  wire logic                    low_freq_osc,
  input  wire logic                    restart,
  input  wire logic                    cfg_wr,
  input  watchdog_pkg::wd_cfg_t        cfg_in,
  output watchdog_pkg::wd_status_t     status,
  output wire logic                    sys_reset_req,
  output wire logic                    rst_pin_out,
  output wire logic                    rst_pin_oe
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  watchdog_pkg::wd_state_t       state_ff;
  watchdog_pkg::wd_state_t       nxt_state;
  logic                          lock_ff;
  logic                          nxt_lock;
  logic [`WD_INTERVAL_W-1:0]     interval_ff;
  logic [`WD_INTERVAL_W-1:0]     nxt_interval;
  logic [CNT_W-1:0]              count_ff;
  logic [CNT_W-1:0]              nxt_count;
  logic                          osc_tick;

  // ----------------------------------------------------------------------
  // Oscillator edge detection
  // ----------------------------------------------------------------------
  osc_edge_sync u_osc_sync
  (
    .clk        (clk),
    .reset      (reset),
    .clk_en     (clk_en),
    .async_in   (low_freq_osc),
    .rise_pulse (osc_tick)
  );

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire logic                cfg_take;
  wire logic [CNT_W:0]      limit_wide;
  wire logic [CNT_W-1:0]    terminal;
  wire logic                running;
  wire logic                at_terminal;
  wire logic                overflow;

  // Locked: every write is dropped whole
  assign cfg_take    = cfg_wr & ~lock_ff;
  // One count is one oscillator period, 12.5 us at nominal rate
  assign limit_wide  = (CNT_W+1)'(1) << (INTERVAL_BASE + int'(interval_ff));
  assign terminal    = limit_wide[CNT_W-1:0] - CNT_W'(1);
  assign running     = (state_ff == watchdog_pkg::ST_RUN);
  assign at_terminal = (count_ff == terminal);
  assign overflow    = running & osc_tick & at_terminal & ~restart;

  always_comb
  begin
    nxt_state    = state_ff;
    nxt_lock     = lock_ff;
    nxt_interval = interval_ff;
    nxt_count    = count_ff;
    case (state_ff)
      watchdog_pkg::ST_RUN:
      begin
        if (overflow)
          nxt_state = watchdog_pkg::ST_FIRED;
        else if (cfg_take && !cfg_in.enable && !cfg_in.lock)
          nxt_state = watchdog_pkg::ST_OFF;
      end
      watchdog_pkg::ST_OFF:
      begin
        if (cfg_take && (cfg_in.enable || cfg_in.lock))
          nxt_state = watchdog_pkg::ST_RUN;
      end
      watchdog_pkg::ST_FIRED:
      begin
        // Holds until the system reset comes back
        nxt_state = watchdog_pkg::ST_FIRED;
      end
      default:
      begin
        nxt_state = watchdog_pkg::ST_RUN;
      end
    endcase

    if (cfg_take)
    begin
      nxt_lock     = cfg_in.lock;
      nxt_interval = cfg_in.interval;
    end

    // Restart beats a same-cycle tick; interval change also restarts count
    if (restart || cfg_take || state_ff != watchdog_pkg::ST_RUN)
      nxt_count = '0;
    else if (osc_tick && !at_terminal)
      nxt_count = count_ff + CNT_W'(1);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff    <= watchdog_pkg::ST_RUN;
      lock_ff     <= `WD_LOCK_RST;
      interval_ff <= `WD_INTERVAL_RST;
      count_ff    <= '0;
    end
    else if (clk_en)
    begin
      state_ff    <= nxt_state;
      lock_ff     <= nxt_lock;
      interval_ff <= nxt_interval;
      count_ff    <= nxt_count;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign sys_reset_req   = (state_ff == watchdog_pkg::ST_FIRED);
  // Pin never driven: internal reset only
  assign rst_pin_out     = 1'h0;
  assign rst_pin_oe      = 1'h0;

  // One driver for the whole struct
  assign status = {(state_ff != watchdog_pkg::ST_OFF), lock_ff, sys_reset_req, interval_ff, count_ff};

endmodule : watchdog_unit

// ---- bench/lowfreq_watchdog_reset_props.sv ----
// Checker for watchdog_unit port behaviour.
// Assumes one clock domain and asynchronous active-high reset.
`timescale 1ns/100ps
module lowfreq_watchdog_reset_props
(
  input wire logic                 clk,
  input wire logic                 reset,
  input wire logic                 clk_en,
  input wire logic                 restart,
  input wire logic                 cfg_wr,
  input watchdog_pkg::wd_cfg_t     cfg_in,
  input watchdog_pkg::wd_status_t  status,
  input wire logic                 sys_reset_req,
  input wire logic                 rst_pin_out,
  input wire logic                 rst_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_restart; clk_en && restart; endsequence
  sequence s_open_wr; clk_en && cfg_wr && !status.locked; endsequence
  a_pin_untouched: assert property (!rst_pin_oe && !rst_pin_out) else $error("pin driven");
  a_fire_resets: assert property ($rose(sys_reset_req) |-> $past(status.count) != 16'h0000) else $error("early reset request");
  a_req_holds: assert property (sys_reset_req |=> sys_reset_req) else $error("request dropped");
  a_restart_clears: assert property (s_restart |=> status.count == 16'h0000) else $error("count kept");
  a_lock_sticks: assert property (status.locked |=> status.locked && status.enabled) else $error("lock lost");
  a_locked_frozen: assert property (status.locked |=> $stable(status.interval)) else $error("cfg moved");
  a_cfg_takes: assert property (s_open_wr |=> status.interval == $past(cfg_in.interval)) else $error("cfg lost");
  a_count_step: assert property (status.count != 16'h0000 && !$stable(status.count)
    |-> status.count == $past(status.count) + 16'h0001) else $error("count jump");
  a_hold_frozen: assert property (!clk_en |=> $stable(status)) else $error("moved while frozen");
endmodule : lowfreq_watchdog_reset_props
bind watchdog_unit lowfreq_watchdog_reset_props u_props (.clk(clk), .reset(reset), .clk_en(clk_en),
  .restart(restart), .cfg_wr(cfg_wr), .cfg_in(cfg_in), .status(status), .sys_reset_req(sys_reset_req),
  .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe));

// ---- bench/tb_lowfreq_watchdog_reset.sv ----
// Self-checking bench for watchdog_unit.
// Assumes INTERVAL_BASE 1: interval i overflows after 2^(1+i) ticks.
`timescale 1ns/100ps
module tb_lowfreq_watchdog_reset;
  logic clk = 1'b0, reset = 1'b1, clk_en = 1'b1, osc = 1'b0, restart = 1'b0, cfg_wr = 1'b0;
  watchdog_pkg::wd_cfg_t    cfg_in = '0;
  watchdog_pkg::wd_status_t status;
  logic req, pin_out, pin_oe;
  int fail_count = 0, cmp_count = 0, n;
  always #50 clk = ~clk;
  // Free-running 80 kHz source, rising edges land on clk rising edges
  always #6250 osc = ~osc;
  watchdog_unit #(.INTERVAL_BASE(1)) u_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .low_freq_osc(osc),
    .restart(restart), .cfg_wr(cfg_wr), .cfg_in(cfg_in), .status(status), .sys_reset_req(req),
    .rst_pin_out(pin_out), .rst_pin_oe(pin_oe));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  task chk_range(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi)
    begin
      fail_count++;
      $display("wrong value at %0t: wait %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_range
  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  task do_reset;
    reset <= 1'b1;
    cyc(12);
    reset <= 1'b0;
    cyc(1);
    chk({status.enabled, status.locked, status.fired, status.interval}, 32'h0000_0027);
    chk({req, pin_oe, pin_out, status.count}, 32'h0000_0000);
  endtask : do_reset
  task wr(input logic e, input logic l, input logic [2:0] i);
    cfg_wr <= 1'b1;
    cfg_in <= {e, l, i};
    cyc(1);
    cfg_wr <= 1'b0;
    cyc(1);
  endtask : wr
  task wait_req;
    n = 0;
    while (req !== 1'b1 && n < 40000)
    begin
      cyc(1);
      n++;
    end
  endtask : wait_req
  task t_default_timeout;
    wait_req;
    chk_range(n, 31870, 32010);
    chk({status.fired, pin_oe, pin_out}, 32'h0000_0004);
    do_reset;
  endtask : t_default_timeout
  task t_restart_and_hold;
    wr(1'b1, 1'b0, 3'h0);
    repeat (10)
    begin
      cyc(100);
      restart <= 1'b1;
      cyc(1);
      restart <= 1'b0;
    end
    clk_en <= 1'b0;
    cyc(400);
    clk_en <= 1'b1;
    cyc(1);
    chk(req, 1'b0);
    cyc(4);
    restart <= 1'b1;
    cyc(1);
    restart <= 1'b0;
    wait_req;
    chk_range(n, 120, 260);
    do_reset;
  endtask : t_restart_and_hold
  task t_disable_then_lock;
    wr(1'b0, 1'b0, 3'h0);
    cyc(600);
    chk({status.enabled, req, status.count}, 32'h0000_0000);
    wr(1'b1, 1'b1, 3'h0);
    wr(1'b0, 1'b0, 3'h5);
    chk({status.enabled, status.locked, status.interval}, 32'h0000_0018);
    wait_req;
    chk_range(n, 120, 260);
    do_reset;
  endtask : t_disable_then_lock
  task results;
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  initial
  begin
    #5_000_000;
    fail_count++;
    results;
  end
  initial
  begin
    do_reset;
    t_default_timeout;
    t_restart_and_hold;
    t_disable_then_lock;
    results;
  end
endmodule : tb_lowfreq_watchdog_reset
